/* rtl/mcsp_pkg.sv */
// Functional notes
// - Writing the main select bit switches the main clock glitch-free, then sets select status.
// - Select status with its mask bit set raises the interrupt request.
// - Fast RC is the main source at reset and on every Wait mode entry.
// - The frequency meter counts only the selected main clock.
// - Stable source, selection change or restart write restarts the meter at slow rise.
// - The sixteenth slow falling edge stops the meter and sets the ready flag.
// - PLL output is slow clock times multiplier plus one.
// - Multiplier or enable field zero powers the PLL down two slow cycles later.
// - PLL re-enable or change clears lock, counts lock count down on slow clock.
// - Half-divide bit in the master clock register divides the PLL clock by two.
// - The multiplier sent to the PLL is clamped to the ceiling field.
// - After reset the fast RC runs at its 8 MHz setting.
// - Slow clock source choice disables whichever slow oscillator is unused.
// - Crystal enable clears stable flag, counts startup on slow clock over 8.
// - RC frequency change clears RC stable and, while RC is the selected source, stops the main clock until settled.
package mcsp_pkg;
   localparam logic [7:0] OFS_MAIN_OSC  = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_FREQ_MTR  = 8'h08;
   localparam logic [7:0] OFS_MCK       = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
   localparam logic [7:0] OFS_PLL_CFG   = 8'h14;
   localparam logic [7:0] OFS_PLL_MAX   = 8'h18;
   // main_osc_reg fields
   localparam int BIT_XT_EN   = 0;
   localparam int BIT_XT_BYP  = 1;
   localparam int BIT_RC_EN   = 3;
   localparam int POS_RC_FREQ = 4;
   localparam int POS_XT_ST   = 8;
   localparam int BIT_SEL     = 24;
   // pm_status_reg and irq_mask_reg fields
   localparam int BIT_XT_STB  = 0;
   localparam int BIT_LOCK    = 1;
   localparam int BIT_MCK_RDY = 3;
   localparam int BIT_SEL_STS = 16;
   localparam int BIT_RC_STB  = 17;
   // freq_meter_reg fields
   localparam int BIT_MF_RDY  = 16;
   localparam int BIT_RESTART = 20;
   // master_clk_reg fields
   localparam int BIT_HALF    = 12;
   // pll_config_reg fields
   localparam int POS_PLL_EN  = 0;
   localparam int POS_LOCK_CT = 8;
   localparam int POS_MUL     = 16;
   // Reset values
   localparam logic [2:0] RST_RC_FREQ = 3'h0;
   localparam logic       RST_RC_EN   = 1'b1;
   // Counts in slow clock cycles; SW_EDGES counts new-source clock edges
   localparam int MEAS_PERIODS  = 16;
   localparam int XT_PRESCALE   = 8;
   localparam int PLL_OFF_DELAY = 2;
   localparam int SW_EDGES      = 2;
   typedef enum logic [1:0] {
      SW_IDLE = 2'b00,
      SW_STOP = 2'b01,
      SW_SYNC = 2'b11
   } mcsp_sw_e;
endpackage

/* rtl/mcsp_main_clock.sv */
`timescale 1ns/10ps
module mcsp_main_clock
   import mcsp_pkg::*;
#(
   parameter int MUL_W = 11,
   parameter int LCK_W = 6,
   parameter int MF_W  = 16
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [31:0]      wdata_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   output logic      [31:0]      rdata_o,
   input  wire logic             rc_clk_i,
   input  wire logic             xtal_clk_i,
   input  wire logic             rc_ready_i,
   input  wire logic             slow_clk_i,
   input  wire logic             wait_mode_i,
   input  wire logic             slow_xtal_sel_i,
   output logic                  main_clk_o,
   output logic                  rc_osc_en_o,
   output logic      [2:0]       rc_freq_sel_o,
   output logic                  xtal_osc_en_o,
   output logic                  xtal_bypass_o,
   output logic                  slow_rc_en_o,
   output logic                  slow_xtal_en_o,
   output logic                  pll_pwr_o,
   output logic      [MUL_W-1:0] pll_mult_o,
   output logic                  pll_div2_o,
   output logic      [1:0]       mck_src_o,
   output logic                  irq_o
);
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   logic             rc_en, rc_stb, rc_wait, xt_en, xt_byp, xt_stb, sel_tgt, sel_cur, sel_sts, gate;
   logic [2:0]       rc_freq, xt_pre;
   logic [7:0]       xt_st, xt_cnt;
   logic             xt_run, slow_q, src_q, mclk, mf_pend, mf_run, mf_rdy, rc_stb_q, xt_stb_q;
   logic [MF_W-1:0]  mf_cnt;
   logic [4:0]       mf_falls;
   logic [1:0]       sw_cnt, off_cnt, mck_src;
   mcsp_sw_e         sw_st;
   logic [7:0]       pll_en;
   logic [LCK_W-1:0] lock_ct, lock_cnt;
   logic [MUL_W-1:0] mul, ceil, mul_out;
   logic             lock, pll_pwr, half, mck_rdy, mck_pend, irq, slow_rc, slow_xt;
   logic [31:0]      mask, rdata;

   logic             next_rc_en, next_rc_stb, next_rc_wait, next_xt_en, next_xt_byp, next_xt_stb;
   logic             next_sel_tgt, next_sel_cur, next_sel_sts, next_gate, next_xt_run, next_mclk;
   logic [2:0]       next_rc_freq, next_xt_pre;
   logic [7:0]       next_xt_st, next_xt_cnt, next_pll_en;
   logic             next_mf_pend, next_mf_run, next_mf_rdy, next_lock, next_pll_pwr, next_half;
   logic             next_mck_rdy, next_mck_pend, next_irq;
   logic [MF_W-1:0]  next_mf_cnt;
   logic [4:0]       next_mf_falls;
   logic [1:0]       next_sw_cnt, next_off_cnt, next_mck_src;
   mcsp_sw_e         next_sw_st;
   logic [LCK_W-1:0] next_lock_ct, next_lock_cnt;
   logic [MUL_W-1:0] next_mul, next_ceil, next_mul_out;
   logic [31:0]      next_mask, next_rdata, status;

   logic slow_rise, slow_fall, cur_lvl, tgt_lvl, pll_on, new_on, pll_chg;
   logic wr_mor, wr_mcfr, wr_mck, wr_pll, wr_max;

   assign slow_rise = slow_clk_i & ~slow_q;
   assign slow_fall = ~slow_clk_i & slow_q;
   assign cur_lvl   = sel_cur ? xtal_clk_i : rc_clk_i;
   assign tgt_lvl   = sel_tgt ? xtal_clk_i : rc_clk_i;
   assign wr_mor    = wr_i & hit(addr_i, OFS_MAIN_OSC);
   assign wr_mcfr   = wr_i & hit(addr_i, OFS_FREQ_MTR);
   assign wr_mck    = wr_i & hit(addr_i, OFS_MCK);
   assign wr_pll    = wr_i & hit(addr_i, OFS_PLL_CFG);
   assign wr_max    = wr_i & hit(addr_i, OFS_PLL_MAX);
   assign pll_on    = (mul != '0) && (pll_en != 8'h00);
   assign new_on    = (wdata_i[POS_MUL +: MUL_W] != '0) && (wdata_i[POS_PLL_EN +: 8] != 8'h00);
   assign pll_chg   = (wr_pll && new_on) || (wr_max && pll_on);

   always_comb begin
      status = '0;
      status[BIT_XT_STB]  = xt_stb;
      status[BIT_LOCK]    = lock;
      status[BIT_MCK_RDY] = mck_rdy;
      status[BIT_SEL_STS] = sel_sts;
      status[BIT_RC_STB]  = rc_stb;
   end

   always_comb begin
      next_rc_en = rc_en;     next_rc_freq = rc_freq; next_rc_stb = rc_stb;   next_rc_wait = rc_wait;
      next_xt_en = xt_en;     next_xt_byp = xt_byp;   next_xt_st = xt_st;     next_xt_stb = xt_stb;
      next_xt_cnt = xt_cnt;   next_xt_pre = xt_pre;   next_xt_run = xt_run;   next_sel_tgt = sel_tgt;
      next_sel_cur = sel_cur; next_sel_sts = sel_sts; next_gate = gate;       next_sw_st = sw_st;
      next_sw_cnt = sw_cnt;   next_mf_pend = mf_pend; next_mf_run = mf_run;   next_mf_rdy = mf_rdy;
      next_mf_cnt = mf_cnt;   next_mf_falls = mf_falls;
      next_pll_en = pll_en;   next_mul = mul;         next_ceil = ceil;       next_lock_ct = lock_ct;
      next_lock_cnt = lock_cnt; next_lock = lock;     next_pll_pwr = pll_pwr; next_off_cnt = off_cnt;
      next_half = half;       next_mck_src = mck_src; next_mck_rdy = mck_rdy; next_mck_pend = mck_pend;
      next_mask = mask;       next_rdata = '0;

      // Oscillator control
      if (wr_mor) begin
         next_xt_byp  = wdata_i[BIT_XT_BYP];
         next_xt_st   = wdata_i[POS_XT_ST +: 8];
         next_sel_tgt = wdata_i[BIT_SEL];
         next_rc_en   = wdata_i[BIT_RC_EN];
         next_xt_en   = wdata_i[BIT_XT_EN];
         if (!wdata_i[BIT_RC_EN]) begin
            next_rc_stb  = 1'b0;
            next_rc_wait = 1'b0;
         end else if (!rc_en || wdata_i[POS_RC_FREQ +: 3] != rc_freq) begin
            next_rc_freq = wdata_i[POS_RC_FREQ +: 3];
            next_rc_stb  = 1'b0;
            next_rc_wait = 1'b1;
         end
         if (wdata_i[BIT_XT_EN] && !xt_en) begin
            next_xt_stb = 1'b0;
            next_xt_cnt = wdata_i[POS_XT_ST +: 8];
            next_xt_pre = '0;
            next_xt_run = 1'b1;
         end else if (!wdata_i[BIT_XT_EN]) begin
            next_xt_stb = 1'b0;
            next_xt_run = 1'b0;
         end
      end
      if (wait_mode_i)
         next_sel_tgt = 1'b0;
      // RC must see a slow edge before its ready is trusted after a change
      if (rc_wait && slow_rise && rc_ready_i && !wr_mor) begin
         next_rc_wait = 1'b0;
         next_rc_stb  = 1'b1;
      end
      if (xt_run && slow_rise && !(wr_mor && !wdata_i[BIT_XT_EN])) begin
         next_xt_pre = xt_pre + 3'h1;
         if (xt_pre == 3'(XT_PRESCALE - 1)) begin
            if (xt_cnt <= 8'h01) begin
               next_xt_cnt = 8'h00;
               next_xt_stb = 1'b1;
               next_xt_run = 1'b0;
            end else begin
               next_xt_cnt = xt_cnt - 8'h01;
            end
         end
      end

      // Glitch-free switch: park low on old source, then wait new-source edges
      case (sw_st)
         SW_IDLE: begin
            if (next_sel_tgt != sel_cur) begin
               next_sel_sts = 1'b0;
               next_sw_st   = SW_STOP;
            end
         end
         SW_STOP: begin
            if (!cur_lvl) begin
               next_gate   = 1'b0;
               next_sw_cnt = '0;
               next_sw_st  = SW_SYNC;
            end
         end
         SW_SYNC: begin
            if (next_sel_tgt != sel_tgt) begin
               next_sw_cnt = '0;
            end else if (tgt_lvl && !src_q) begin
               // Absent crystal never gives edges: status stays low
               next_sw_cnt = sw_cnt + 2'h1;
               if (sw_cnt == 2'(SW_EDGES - 1)) begin
                  next_sel_cur = sel_tgt;
                  next_gate    = 1'b1;
                  next_sel_sts = 1'b1;
                  next_mf_pend = 1'b1;
                  next_sw_st   = SW_IDLE;
               end
            end
         end
         default: next_sw_st = SW_IDLE;
      endcase
      next_mclk = gate && cur_lvl && !(rc_wait && !sel_cur);

      // Frequency meter
      if ((rc_stb && !rc_stb_q && !sel_cur) || (xt_stb && !xt_stb_q && sel_cur) ||
          (wr_mcfr && wdata_i[BIT_RESTART]))
         next_mf_pend = 1'b1;
      if (mf_pend && slow_rise) begin
         next_mf_pend  = 1'b0;
         next_mf_run   = 1'b1;
         next_mf_rdy   = 1'b0;
         next_mf_cnt   = '0;
         next_mf_falls = '0;
      end else if (mf_run) begin
         if (next_mclk && !mclk)
            next_mf_cnt = mf_cnt + 1'b1;
         if (slow_fall) begin
            next_mf_falls = mf_falls + 5'h01;
            if (mf_falls == 5'(MEAS_PERIODS - 1)) begin
               next_mf_run = 1'b0;
               next_mf_rdy = 1'b1;
            end
         end
      end

      // PLL
      if (wr_pll) begin
         next_pll_en  = wdata_i[POS_PLL_EN +: 8];
         next_lock_ct = wdata_i[POS_LOCK_CT +: LCK_W];
         next_mul     = wdata_i[POS_MUL +: MUL_W];
      end
      if (wr_max)
         next_ceil = wdata_i[MUL_W-1:0];
      next_mul_out = (next_mul > next_ceil) ? next_ceil : next_mul;
      if (pll_chg) begin
         next_lock     = 1'b0;
         next_lock_cnt = wr_pll ? wdata_i[POS_LOCK_CT +: LCK_W] : lock_ct;
         next_pll_pwr  = 1'b1;
         next_off_cnt  = '0;
      end else if (wr_pll) begin
         next_lock    = 1'b0;
         next_off_cnt = 2'(PLL_OFF_DELAY);
      end else begin
         if (pll_on && !lock && slow_rise) begin
            if (lock_cnt == '0)
               next_lock = 1'b1;
            else
               next_lock_cnt = lock_cnt - 1'b1;
         end
         if (off_cnt != 2'h0 && slow_rise) begin
            next_off_cnt = off_cnt - 2'h1;
            if (off_cnt == 2'h1)
               next_pll_pwr = 1'b0;
         end
      end

      // Master clock register
      if (wr_mck) begin
         next_mck_src  = wdata_i[1:0];
         next_half     = wdata_i[BIT_HALF];
         next_mck_rdy  = 1'b0;
         next_mck_pend = 1'b1;
      end else if (mck_pend && slow_rise) begin
         next_mck_pend = 1'b0;
         next_mck_rdy  = 1'b1;
      end
      if (wr_i && hit(addr_i, OFS_IRQ_MASK))
         next_mask = wdata_i;
      next_irq = |(status & mask);

      if (rd_i) begin
         if (hit(addr_i, OFS_MAIN_OSC)) begin
            next_rdata[BIT_XT_EN]           = xt_en;
            next_rdata[BIT_XT_BYP]          = xt_byp;
            next_rdata[BIT_RC_EN]           = rc_en;
            next_rdata[POS_RC_FREQ +: 3]    = rc_freq;
            next_rdata[POS_XT_ST +: 8]      = xt_st;
            next_rdata[BIT_SEL]             = sel_tgt;
         end else if (hit(addr_i, OFS_STATUS)) begin
            next_rdata = status;
         end else if (hit(addr_i, OFS_FREQ_MTR)) begin
            next_rdata[MF_W-1:0]  = mf_cnt;
            next_rdata[BIT_MF_RDY] = mf_rdy;
         end else if (hit(addr_i, OFS_MCK)) begin
            next_rdata[1:0]      = mck_src;
            next_rdata[BIT_HALF] = half;
         end else if (hit(addr_i, OFS_IRQ_MASK)) begin
            next_rdata = mask;
         end else if (hit(addr_i, OFS_PLL_CFG)) begin
            next_rdata[POS_PLL_EN +: 8]      = pll_en;
            next_rdata[POS_LOCK_CT +: LCK_W] = lock_ct;
            next_rdata[POS_MUL +: MUL_W]     = mul;
         end else if (hit(addr_i, OFS_PLL_MAX)) begin
            next_rdata[MUL_W-1:0] = ceil;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rc_en <= RST_RC_EN; rc_freq <= RST_RC_FREQ; rc_stb <= 1'b1; rc_wait <= 1'b0;
         xt_en <= 1'b0; xt_byp <= 1'b0; xt_st <= 8'h00; xt_stb <= 1'b0; xt_cnt <= 8'h00;
         xt_pre <= 3'h0; xt_run <= 1'b0;
         sel_tgt <= 1'b0; sel_cur <= 1'b0; sel_sts <= 1'b0; gate <= 1'b1; sw_st <= SW_IDLE;
         sw_cnt <= 2'h0; slow_q <= 1'b0; src_q <= 1'b0; mclk <= 1'b0; rc_stb_q <= 1'b1; xt_stb_q <= 1'b0;
         mf_pend <= 1'b1; mf_run <= 1'b0; mf_rdy <= 1'b0; mf_cnt <= '0; mf_falls <= 5'h00;
         pll_en <= 8'h00; mul <= '0; ceil <= '1; lock_ct <= '0; lock_cnt <= '0; lock <= 1'b0;
         pll_pwr <= 1'b0; off_cnt <= 2'h0; mul_out <= '0; half <= 1'b0; mck_src <= 2'h1;
         mck_rdy <= 1'b1; mck_pend <= 1'b0; mask <= '0; irq <= 1'b0; rdata <= '0;
         slow_rc <= 1'b1; slow_xt <= 1'b0;
      end else if (ce_i) begin
         rc_en <= next_rc_en; rc_freq <= next_rc_freq; rc_stb <= next_rc_stb; rc_wait <= next_rc_wait;
         xt_en <= next_xt_en; xt_byp <= next_xt_byp; xt_st <= next_xt_st; xt_stb <= next_xt_stb;
         xt_cnt <= next_xt_cnt; xt_pre <= next_xt_pre; xt_run <= next_xt_run;
         sel_tgt <= next_sel_tgt; sel_cur <= next_sel_cur; sel_sts <= next_sel_sts; gate <= next_gate;
         sw_st <= next_sw_st; sw_cnt <= next_sw_cnt; slow_q <= slow_clk_i; src_q <= tgt_lvl;
         mclk <= next_mclk; rc_stb_q <= rc_stb; xt_stb_q <= xt_stb;
         mf_pend <= next_mf_pend; mf_run <= next_mf_run; mf_rdy <= next_mf_rdy;
         mf_cnt <= next_mf_cnt; mf_falls <= next_mf_falls;
         pll_en <= next_pll_en; mul <= next_mul; ceil <= next_ceil; lock_ct <= next_lock_ct;
         lock_cnt <= next_lock_cnt; lock <= next_lock; pll_pwr <= next_pll_pwr; off_cnt <= next_off_cnt;
         mul_out <= next_mul_out; half <= next_half; mck_src <= next_mck_src;
         mck_rdy <= next_mck_rdy; mck_pend <= next_mck_pend; mask <= next_mask; irq <= next_irq;
         rdata <= next_rdata;
         slow_rc <= !slow_xtal_sel_i;
         slow_xt <= slow_xtal_sel_i;
      end
   end

   assign rdata_o        = rdata;
   assign main_clk_o     = mclk;
   assign rc_osc_en_o    = rc_en;
   assign rc_freq_sel_o  = rc_freq;
   assign xtal_osc_en_o  = xt_en;
   assign xtal_bypass_o  = xt_byp;
   assign slow_rc_en_o   = slow_rc;
   assign slow_xtal_en_o = slow_xt;
   assign pll_pwr_o      = pll_pwr;
   assign pll_mult_o     = mul_out;
   assign pll_div2_o     = half;
   assign mck_src_o      = mck_src;
   assign irq_o          = irq;
endmodule

/* testbench/mcsp_main_clock_monitor.sv */
`timescale 1ns/10ps
module mcsp_main_clock_monitor
   import mcsp_pkg::*;
#(
   parameter int MUL_W = 11
) (
   input wire logic             ref_clk_i,
   input wire logic             rst_i,
   input wire logic             ce_i,
   input wire logic [7:0]       addr_i,
   input wire logic [31:0]      wdata_i,
   input wire logic             wr_i,
   input wire logic             slow_xtal_sel_i,
   input wire logic             rc_osc_en_o,
   input wire logic [2:0]       rc_freq_sel_o,
   input wire logic             xtal_osc_en_o,
   input wire logic             xtal_bypass_o,
   input wire logic             slow_rc_en_o,
   input wire logic             slow_xtal_en_o,
   input wire logic             pll_pwr_o,
   input wire logic [MUL_W-1:0] pll_mult_o,
   input wire logic             pll_div2_o
);
   logic [MUL_W-1:0] ceil_q;
   logic             cfg_on;
   logic             cfg_off;
   logic             osc_wr;
   assign osc_wr  = wr_i && ce_i && addr_i == OFS_MAIN_OSC;
   assign cfg_on  = wr_i && ce_i && addr_i == OFS_PLL_CFG && wdata_i[7:0] != 8'h00 && wdata_i[POS_MUL+:MUL_W] != '0;
   assign cfg_off = wr_i && ce_i && addr_i == OFS_PLL_CFG && !(wdata_i[7:0] != 8'h00 && wdata_i[POS_MUL+:MUL_W] != '0);
   // Shadow of the ceiling, needed to judge the clamp
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ceil_q <= '1;
      end else if (wr_i && ce_i && addr_i == OFS_PLL_MAX) begin
         ceil_q <= wdata_i[MUL_W-1:0];
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_reset_rc_8mhz: assert property ($fell(rst_i) |-> rc_osc_en_o && rc_freq_sel_o == RST_RC_FREQ)
      else $error("fast RC not at its reset setting");
   a_half_div_follow: assert property (wr_i && ce_i && addr_i == OFS_MCK |=> pll_div2_o == $past(wdata_i[BIT_HALF]))
      else $error("half divide output does not follow write");
   a_pll_off_delay: assert property (cfg_off && pll_pwr_o |-> pll_pwr_o [*8] ##[1:33] !pll_pwr_o)
      else $error("PLL not powered down in time");
   a_pll_on_power: assert property (cfg_on |=> pll_pwr_o)
      else $error("PLL not powered after enabling write");
   a_mult_clamped: assert property (cfg_on |=> pll_mult_o == ($past(wdata_i[POS_MUL+:MUL_W]) > ceil_q ? ceil_q
      : $past(wdata_i[POS_MUL+:MUL_W]))) else $error("multiplier not clamped to ceiling");
   a_slow_osc_pick: assert property ($past(ce_i) |-> slow_xtal_en_o == $past(slow_xtal_sel_i)
      && slow_rc_en_o == !$past(slow_xtal_sel_i)) else $error("unused slow oscillator left enabled");
   a_rc_ctrl_follow: assert property (osc_wr && wdata_i[BIT_RC_EN] |=> rc_osc_en_o
      && rc_freq_sel_o == $past(wdata_i[POS_RC_FREQ+:3])) else $error("RC control does not follow write");
   a_xtal_ctrl_follow: assert property (osc_wr |=> xtal_osc_en_o == $past(wdata_i[BIT_XT_EN])
      && xtal_bypass_o == $past(wdata_i[BIT_XT_BYP])) else $error("crystal control does not follow write");
endmodule

/* testbench/mcsp_osc_model.sv */
`timescale 1ns/10ps
module mcsp_osc_model (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       rc_osc_en_i,
   input  wire logic [2:0] rc_freq_sel_i,
   input  wire logic       xtal_osc_en_i,
   input  wire logic       xtal_bypass_i,
   input  wire logic       xtal_present_i,
   output logic            rc_clk_o,
   output logic            xtal_clk_o,
   output logic            rc_ready_o,
   output logic            slow_clk_o
);
   logic [3:0] phase;
   logic [4:0] settle;
   logic [3:0] rc_cfg_q;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         phase    <= 4'h0;
         settle   <= 5'h00;
         rc_cfg_q <= 4'h8;
      end else begin
         phase    <= phase + 4'h1;
         rc_cfg_q <= {rc_osc_en_i, rc_freq_sel_i};
         // Any RC retune costs a settling time before ready returns
         if ({rc_osc_en_i, rc_freq_sel_i} != rc_cfg_q) begin
            settle <= 5'h14;
         end else if (settle != 5'h00) begin
            settle <= settle - 5'h01;
         end
      end
   end
   assign slow_clk_o = phase[3];
   assign rc_clk_o   = rc_osc_en_i & phase[1];
   // Missing crystal or bypass with no source: pin stuck low
   assign xtal_clk_o = (xtal_osc_en_i | xtal_bypass_i) & xtal_present_i & phase[2];
   assign rc_ready_o = rc_osc_en_i && settle == 5'h00 && {rc_osc_en_i, rc_freq_sel_i} == rc_cfg_q;
endmodule

/* testbench/test_main_clock_select_pll_control.sv */
`timescale 1ns/10ps
module test_main_clock_select_pll_control;
   import mcsp_pkg::*;
   localparam int          RC_CNT = MEAS_PERIODS * 16 / 4;
   localparam int          XT_CNT = MEAS_PERIODS * 16 / 8;
   localparam logic [31:0] RC     = (32'h1 << BIT_RC_EN) | (32'h2 << POS_XT_ST);
   localparam logic [31:0] XT     = 32'h1 << BIT_XT_EN;
   localparam logic [31:0] BY     = 32'h1 << BIT_XT_BYP;
   localparam logic [31:0] SEL    = 32'h1 << BIT_SEL;
   logic        ref_clk_i, rst_i, ce_i, wr_i, rd_i, wait_mode_i, slow_xtal_sel_i, xtal_present;
   logic        rc_clk_i, xtal_clk_i, rc_ready_i, slow_clk_i, main_clk_o, rc_osc_en_o, xtal_osc_en_o;
   logic        xtal_bypass_o, slow_rc_en_o, slow_xtal_en_o, pll_pwr_o, pll_div2_o, irq_o;
   logic [2:0]  rc_freq_sel_o;
   logic [10:0] pll_mult_o;
   logic [1:0]  mck_src_o;
   logic [7:0]  addr_i;
   logic [31:0] wdata_i, rdata_o, v;
   int          n_fail = 0;
   int          compares = 0;
   mcsp_main_clock u_mcsp_main_clock (.ref_clk_i, .rst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .rc_clk_i, .xtal_clk_i, .rc_ready_i, .slow_clk_i, .wait_mode_i, .slow_xtal_sel_i, .main_clk_o, .rc_osc_en_o,
      .rc_freq_sel_o, .xtal_osc_en_o, .xtal_bypass_o, .slow_rc_en_o, .slow_xtal_en_o, .pll_pwr_o, .pll_mult_o,
      .pll_div2_o, .mck_src_o, .irq_o);
   mcsp_osc_model u_mcsp_osc_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .rc_osc_en_i(rc_osc_en_o),
      .rc_freq_sel_i(rc_freq_sel_o), .xtal_osc_en_i(xtal_osc_en_o), .xtal_bypass_i(xtal_bypass_o),
      .xtal_present_i(xtal_present), .rc_clk_o(rc_clk_i), .xtal_clk_o(xtal_clk_i), .rc_ready_o(rc_ready_i),
      .slow_clk_o(slow_clk_i));
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s: got %h want %h", $time, msg, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i   <= 1'b0;
      @(negedge ref_clk_i);
      d = rdata_o;
   endtask
   task automatic poll(input logic [7:0] a, input int b, input logic val, input string msg);
      logic [31:0] d;
      for (int i = 0; i < 400; i++) begin
         rd(a, d);
         if (d[b] === val) break;
      end
      chk(d[b], val, msg);
   endtask
   task automatic meter(input int exp, input string msg);
      logic [31:0] d;
      wr(OFS_FREQ_MTR, 32'h1 << BIT_RESTART);
      repeat (20) @(posedge ref_clk_i);
      rd(OFS_FREQ_MTR, d);
      chk(d[BIT_MF_RDY], 1'b0, "meter not restarted");
      poll(OFS_FREQ_MTR, BIT_MF_RDY, 1'b1, "meter ready");
      rd(OFS_FREQ_MTR, d);
      chk(d[15:0] + 3 >= exp && d[15:0] <= exp + 3, 1'b1, msg);
   endtask
   task automatic conclude;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Whole sequence needs well under 15000 cycles
   initial begin
      repeat (30000) @(posedge ref_clk_i);
      n_fail++;
      $display("watchdog expired");
      conclude;
   end
   initial begin
      {rst_i, ce_i, wr_i, rd_i, wait_mode_i, slow_xtal_sel_i, xtal_present} = 7'b1100000;
      addr_i  = 8'h00;
      wdata_i = 32'h0;
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      rd(OFS_MAIN_OSC, v);
      chk({v[BIT_SEL], v[BIT_RC_EN], v[6:4]}, 5'h08, "main osc reset");
      chk({rc_osc_en_o, rc_freq_sel_o, mck_src_o}, {RST_RC_EN, RST_RC_FREQ, 2'h1}, "clock reset");
      rd(OFS_STATUS, v);
      chk({v[BIT_RC_STB], v[BIT_SEL_STS], v[BIT_MCK_RDY], v[BIT_LOCK]}, 4'hA, "status reset");
      rd(OFS_PLL_MAX, v);
      chk(v[10:0], 11'h7FF, "ceiling reset");
      rd(8'h40, v);
      chk(v, 32'h0, "unmapped read");
      meter(RC_CNT, "rc count");
      $display("reset and meter test done");
      wr(OFS_MCK, 32'h0);
      poll(OFS_STATUS, BIT_MCK_RDY, 1'b1, "master ready");
      wr(OFS_MAIN_OSC, RC | XT);
      rd(OFS_STATUS, v);
      chk(v[BIT_XT_STB], 1'b0, "stable cleared");
      repeat (90) @(posedge ref_clk_i);
      rd(OFS_STATUS, v);
      chk(v[BIT_XT_STB], 1'b0, "stable too early");
      poll(OFS_STATUS, BIT_XT_STB, 1'b1, "crystal stable");
      wr(OFS_MAIN_OSC, RC | XT | SEL);
      poll(OFS_MAIN_OSC, BIT_SEL, 1'b1, "select readback");
      repeat (60) @(posedge ref_clk_i);
      rd(OFS_STATUS, v);
      chk(v[BIT_SEL_STS], 1'b0, "absent crystal");
      wr(OFS_MAIN_OSC, RC | XT);
      poll(OFS_STATUS, BIT_SEL_STS, 1'b1, "back on RC");
      @(posedge ref_clk_i);
      xtal_present <= 1'b1;
      wr(OFS_MAIN_OSC, RC | XT | SEL);
      wr(OFS_MAIN_OSC, RC | XT);
      wr(OFS_MAIN_OSC, RC | XT | SEL);
      poll(OFS_STATUS, BIT_SEL_STS, 1'b1, "on crystal");
      meter(XT_CNT, "crystal count");
      wr(OFS_MAIN_OSC, RC | XT | BY | SEL);
      wr(OFS_MAIN_OSC, RC | BY | SEL);
      @(negedge ref_clk_i);
      chk({xtal_bypass_o, xtal_osc_en_o}, 2'b10, "bypass");
      $display("crystal test done");
      wr(OFS_MAIN_OSC, RC | BY);
      poll(OFS_STATUS, BIT_SEL_STS, 1'b1, "RC reselected");
      wr(OFS_MAIN_OSC, RC | BY | (32'h1 << POS_RC_FREQ));
      rd(OFS_STATUS, v);
      chk({v[BIT_RC_STB], 1'b0, rc_freq_sel_o}, 5'h01, "RC retune");
      poll(OFS_STATUS, BIT_RC_STB, 1'b1, "RC stable");
      wr(OFS_MAIN_OSC, RC | BY);
      poll(OFS_STATUS, BIT_RC_STB, 1'b1, "RC stable again");
      $display("RC test done");
      wr(OFS_MCK, 32'h1);
      wr(OFS_PLL_MAX, 32'h5);
      wr(OFS_PLL_CFG, (32'h9 << POS_MUL) | (32'h3 << POS_LOCK_CT) | 32'h1);
      @(negedge ref_clk_i);
      chk({pll_pwr_o, pll_mult_o}, {1'b1, 11'h005}, "clamp");
      rd(OFS_STATUS, v);
      chk(v[BIT_LOCK], 1'b0, "lock cleared");
      poll(OFS_STATUS, BIT_LOCK, 1'b1, "lock");
      wr(OFS_PLL_CFG, (32'h4 << POS_MUL) | (32'h3 << POS_LOCK_CT) | 32'h1);
      @(negedge ref_clk_i);
      chk(pll_mult_o, 11'h004, "multiplier");
      wr(OFS_PLL_CFG, (32'h3 << POS_LOCK_CT) | 32'h1);
      @(negedge ref_clk_i);
      chk(pll_pwr_o, 1'b1, "off too early");
      repeat (40) @(posedge ref_clk_i);
      rd(OFS_STATUS, v);
      chk({pll_pwr_o, v[BIT_LOCK]}, 2'b00, "PLL off");
      wr(OFS_MCK, 32'h1 | (32'h1 << BIT_HALF));
      @(negedge ref_clk_i);
      chk(pll_div2_o, 1'b1, "half divide");
      $display("PLL test done");
      wr(OFS_IRQ_MASK, 32'h1 << BIT_SEL_STS);
      repeat (3) @(negedge ref_clk_i);
      chk(irq_o, 1'b1, "irq raised");
      wr(OFS_IRQ_MASK, 32'h1 << BIT_LOCK);
      repeat (3) @(negedge ref_clk_i);
      chk(irq_o, 1'b0, "irq masked");
      @(posedge ref_clk_i);
      slow_xtal_sel_i <= 1'b1;
      repeat (2) @(negedge ref_clk_i);
      chk({slow_rc_en_o, slow_xtal_en_o}, 2'b01, "slow pick");
      @(posedge ref_clk_i);
      ce_i <= 1'b0;
      wr(OFS_PLL_MAX, 32'h3);
      ce_i <= 1'b1;
      rd(OFS_PLL_MAX, v);
      chk(v[10:0], 11'h005, "frozen write");
      wr(OFS_MAIN_OSC, RC | BY | SEL);
      poll(OFS_STATUS, BIT_SEL_STS, 1'b1, "crystal again");
      @(posedge ref_clk_i);
      wait_mode_i <= 1'b1;
      repeat (40) @(posedge ref_clk_i);
      meter(RC_CNT, "wait mode on RC");
      $display("irq and wait test done");
      conclude;
   end
endmodule
bind mcsp_main_clock mcsp_main_clock_monitor #(.MUL_W(MUL_W)) u_mcsp_main_clock_monitor (.ref_clk_i, .rst_i, .ce_i,
   .addr_i, .wdata_i, .wr_i, .slow_xtal_sel_i, .rc_osc_en_o, .rc_freq_sel_o, .xtal_osc_en_o, .xtal_bypass_o,
   .slow_rc_en_o, .slow_xtal_en_o, .pll_pwr_o, .pll_mult_o, .pll_div2_o);
